// ---- bench/crssu_chk.sv ----
// Port-level assertions for the register, stack and status core
`timescale 1ns/100ps
`default_nettype none
module crssu_chk
(
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [1:0]  regbank_select_i,
  input wire logic [1:0]  active_bank_o,
  input wire logic        regbank_expand_flag_o,
  input wire logic        membank_expand_flag_o,
  input wire logic        push_i,
  input wire logic        pop_i,
  input wire logic [11:0] stack_addr_o,
  input wire logic [7:0]  stack_pointer_o,
  input wire logic [3:0]  stack_bank_select_o,
  input wire logic        call_i,
  input wire logic        irq_accept_i,
  input wire logic        interrupt_return_op_i,
  input wire logic [1:0]  irq_level_o,
  input wire logic [7:0]  psw_save_o,
  input wire logic [7:0]  psw_restore_i,
  input wire logic [7:0]  status_word_o,
  input wire logic        mem_en_i,
  input wire logic        mem_we_i,
  input wire logic        mem_wide_i,
  input wire logic [11:0] mem_addr_i,
  input wire logic        mem_hit_o,
  input wire logic [7:0]  mem_rdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_bank_and: assert property (active_bank_o ==
    (regbank_select_i & {2{regbank_expand_flag_o}})) else $error("bank");
  a_push_addr: assert property (push_i |-> stack_addr_o ==
    {3'h0, stack_bank_select_o[0], stack_pointer_o - 8'h01})
    else $error("addr");
  a_push_dec: assert property (push_i |=>
    stack_pointer_o == $past(stack_pointer_o) - 8'h01) else $error("push");
  a_pop_inc: assert property (pop_i && !push_i |=>
    stack_pointer_o == $past(stack_pointer_o) + 8'h01) else $error("pop");
  a_irq_step: assert property (irq_accept_i &&
    !interrupt_return_op_i && irq_level_o < 2'h2 |=>
    irq_level_o == $past(irq_level_o) + 2'h1) else $error("level");
  a_call_save: assert property (call_i |-> psw_save_o ==
    {6'h00, membank_expand_flag_o, regbank_expand_flag_o}) else $error("call");
  a_interrupt_return_op_all: assert property (interrupt_return_op_i |=>
    status_word_o == $past(psw_restore_i)) else $error("interrupt_return_op");
  a_sp_read: assert property (mem_en_i && !mem_we_i && mem_wide_i &&
    mem_addr_i == 12'hf80 |=> mem_hit_o && mem_rdata_o ==
    $past(stack_pointer_o)) else $error("sp read");
endmodule // crssu_chk
`default_nettype wire

// ---- bench/crssu_partner.sv ----
// Far-side model: execution control issuing stack and status strobes
`timescale 1ns/100ps
`default_nettype none
module crssu_partner
(
  input  wire logic [0:0] clk_i,
  input  wire logic       nrst_i,
  input  wire logic [2:0] cmd_i,
  input  wire logic [7:0] psw_save_i,
  output logic      [6:0] strobe_o,
  output logic      [7:0] psw_restore_o
);
  logic [7:0] stk [0:3];
  logic [1:0] depth_reg;
  // Strobes: 1 call, 2 ret, 3 irq, 4 interrupt_return_op, 5 push, 6 pop
  assign strobe_o = 7'h01 << cmd_i;
  assign psw_restore_o = stk[depth_reg - 2'h1];
  always @(posedge clk_i)
    if (!nrst_i)
      depth_reg <= 2'h0;
    else if (strobe_o[1] || strobe_o[3])
    begin
      stk[depth_reg] <= psw_save_i;
      depth_reg <= depth_reg + 2'h1;
    end
    else if (strobe_o[2] || strobe_o[4])
      depth_reg <= depth_reg - 2'h1;
endmodule // crssu_partner
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking testbench for the register, stack and status core
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_i = 1'b0, nrst_i = 1'b0, reg_rd_wide_i = 1'b0, reg_rd_alt_i = 1'b0;
  logic reg_wr_i = 1'b0, reg_wr_wide_i = 1'b0, reg_wr_alt_i = 1'b0;
  logic mem_en_i = 1'b0, mem_we_i = 1'b0, mem_wide_i = 1'b0, rh;
  logic irq_rbe_i = 1'b0, irq_mbe_i = 1'b0, carry_bit_i = 1'b0;
  logic carry_arith_i = 1'b0, skip_we_i = 1'b0;
  logic [1:0] regbank_select_i = 2'h0;
  logic [2:0] reg_rd_nib_i = 3'h0, reg_rd_pair_i = 3'h0, skip_i = 3'h0;
  logic [2:0] reg_wr_nib_i = 3'h0, reg_wr_pair_i = 3'h0, cmd = 3'h0;
  logic [3:0] carry_op_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00, mem_wdata_i = 8'h00, rq;
  logic [11:0] mem_addr_i = 12'h000;
  wire push_i, pop_i, call_i, ret_i, irq_accept_i, interrupt_return_op_i;
  wire idle_w, mem_hit_o, carry_flag_o, legacy_mode_o, extended_mode_o;
  wire regbank_expand_flag_o, membank_expand_flag_o;
  wire [1:0] active_bank_o, irq_level_o;
  wire [3:0] stack_bank_select_o;
  wire [7:0] reg_rdata_o, mem_rdata_o, stack_pointer_o, psw_restore_i;
  wire [7:0] psw_save_o, status_word_o;
  wire [11:0] stack_addr_o;
  int mismatches = 0, n_checks = 0, cycles = 0;
  crssu_core uut (.*);
  crssu_partner partner (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_i(cmd),
    .psw_save_i(psw_save_o), .psw_restore_o(psw_restore_i),
    .strobe_o({pop_i, push_i, interrupt_return_op_i, irq_accept_i, ret_i,
      call_i, idle_w}));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [11:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Memory access; the answer of the next edge lands in rh and rq
  task automatic mem(input logic we, wd, input logic [11:0] a,
    input logic [7:0] d);
    {mem_en_i, mem_we_i, mem_wide_i, mem_addr_i, mem_wdata_i} = {1'b1, we,
      wd, a, d};
    cyc();
    {rh, rq} = {mem_hit_o, mem_rdata_o};
    mem_en_i = 1'b0;
    cyc();
  endtask
  task automatic rw(input logic wd, alt, input logic [2:0] s,
    input logic [7:0] d);
    {reg_wr_i, reg_wr_wide_i, reg_wr_alt_i} = {1'b1, wd, alt};
    {reg_wr_pair_i, reg_wr_nib_i, reg_wdata_i} = {s, s, d};
    cyc();
    reg_wr_i = 1'b0;
    cyc();
  endtask
  // Partner command, stack address checked for push and pop in the cycle it stands
  task automatic op(input logic [2:0] c, input logic [11:0] ea);
    cmd = c;
    #1;
    if (c > 3'h4)
      chk("stack addr", ea, stack_addr_o);
    cyc();
    cmd = 3'h0;
    cyc();
  endtask
  task automatic t_regs;
    mem(1'b1, 1'b0, 12'hfb0, 8'h01);
    regbank_select_i = 2'h2;
    cyc();
    chk("bank", 12'h2, active_bank_o);
    rw(1'b1, 1'b0, 3'h0, 8'h5a);
    mem(1'b0, 1'b1, 12'h010, 8'h00);
    chk("xa ram", 12'h5a, rq);
    rw(1'b1, 1'b1, 3'h1, 8'hc3);
    mem(1'b0, 1'b1, 12'h01a, 8'h00);
    chk("alt hl", 12'hc3, rq);
    mem(1'b1, 1'b0, 12'h015, 8'h07);
    mem(1'b1, 1'b0, 12'h012, 8'h09);
    {reg_rd_wide_i, reg_rd_alt_i, reg_rd_pair_i} = {2'h3, 3'h1};
    cyc();
    chk("alt rd", 12'hc3, reg_rdata_o);
    {reg_rd_alt_i, reg_rd_pair_i} = {1'b0, 3'h4};
    cyc();
    chk("dl pair", 12'h79, reg_rdata_o);
    reg_rd_wide_i = 1'b0;
    cyc();
    chk("a nib", 12'h0a, reg_rdata_o);
    mem(1'b1, 1'b0, 12'hfb0, 8'h00);
    chk("bank zero", 12'h0, active_bank_o);
    $display("regs test done");
  endtask
  task automatic t_stack;
    chk("sbs reset", 12'h8, stack_bank_select_o);
    chk("mode", 12'h2, {legacy_mode_o, extended_mode_o});
    mem(1'b1, 1'b0, 12'hf84, 8'h01);
    chk("sbs", 12'h1, stack_bank_select_o);
    mem(1'b1, 1'b1, 12'hf80, 8'h00);
    op(3'h5, 12'h1ff);
    chk("sp", 12'hff, stack_pointer_o);
    mem(1'b1, 1'b1, 12'hf80, 8'h01);
    op(3'h5, 12'h100);
    op(3'h5, 12'h1ff);
    op(3'h6, 12'h1ff);
    mem(1'b0, 1'b1, 12'hf80, 8'h00);
    chk("sp read", 12'h100, {rh, rq});
    mem(1'b0, 1'b0, 12'hf90, 8'h00);
    chk("unmapped", 12'h0, {rh, rq});
    $display("stack test done");
  endtask
  task automatic t_carry;
    logic c;
    c = 1'b0;
    for (int i = 1; i <= 8; i++)
    begin
      carry_op_i = 4'(i);
      carry_bit_i = carry_op_i[0];
      c = (i == 1) ? 1'b1 : (i == 2) ? 1'b0 : (i == 3) ? ~c :
        (i == 4) ? carry_bit_i : (i == 5) ? c & carry_bit_i :
        (i == 6) ? c | carry_bit_i : (i == 7) ? c ^ carry_bit_i : 1'b0;
      cyc();
      chk("carry", c, carry_flag_o);
    end
    carry_op_i = 4'h0;
    {skip_we_i, skip_i} = {1'b1, 3'h5};
    cyc();
    skip_we_i = 1'b0;
    chk("skip", 12'h5, status_word_o[6:4]);
    $display("carry test done");
  endtask
  task automatic t_status;
    mem(1'b1, 1'b0, 12'hfb0, 8'h03);
    op(3'h1, 12'h0);
    mem(1'b1, 1'b0, 12'hfb0, 8'h00);
    op(3'h2, 12'h0);
    chk("ret flags", 12'h3, status_word_o[3:0]);
    chk("rbe", 12'h1, regbank_expand_flag_o);
    irq_mbe_i = 1'b1;
    op(3'h3, 12'h0);
    chk("level one", 12'h6, status_word_o[3:0]);
    chk("mbe", 12'h1, membank_expand_flag_o);
    op(3'h3, 12'h0);
    chk("level two", 12'ha, status_word_o[3:0]);
    chk("level out", 12'h2, irq_level_o);
    op(3'h4, 12'h0);
    mem(1'b0, 1'b1, 12'hfb0, 8'h00);
    chk("interrupt_return_op word", 12'h56, rq);
    mem(1'b1, 1'b0, 12'hfb1, 8'h00);
    chk("high read only", 12'h5, status_word_o[7:4]);
    $display("status test done");
  endtask
  initial
  begin
    cyc(8);
    nrst_i = 1'b1;
    t_stack();
    t_regs();
    t_carry();
    t_status();
    conclude();
  end
endmodule // tb
bind crssu_core crssu_chk chk_i (.*);
`default_nettype wire

// ---- core/crssu_core.v ----
// Register, stack pointer and status word core of a 4-bit CPU
//
// Summary of operation
// [RULE1] Four banks of eight nibble registers, memory-mapped
// [RULE2] Active bank is expand flag AND select
// [RULE3] Nibble access; pairs and pointer pairs eight-bit
// [RULE4] Alternate pairs from bank with bit0 flipped
// [RULE5] Register storage reachable by plain memory access
// [RULE6] A, pair XA, carry serve as accumulators
// [RULE7] Stack bank field picks bank zero or one
// [RULE8] Pointer decrements before push, increments after pop
// [RULE9] Pointer eight-bit, bank select four-bit accessible
// [RULE10] Pointer zero pushes to bank top address
// [RULE11] Stack address wraps inside selected bank
// [RULE12] Reset loads bank select with 1000B
// [RULE13] Bank select bit3 picks legacy or extended mode
// [RULE14] Status word at two nibbles, low writable
// [RULE15] Calls save flags only; interrupts save all
// [RULE16] Carry captures arithmetic overflow or underflow
// [RULE17] Carry set, clear, invert, test, bit logic
// [RULE18] Carry after reset is not to be relied on
// [RULE19] Skip bits written only by execution
// [RULE20] Interrupt level codes zero, one, two used
// [RULE21] Interrupt entry saves level then advances it
// [RULE22] Software disables interrupts around level writes
// [RULE23] Expand flag clear forces bank zero
`timescale 1ns/100ps
`default_nettype none
`include "crssu_defines.vh"
module crssu_core
(
  input  wire        clk_i,
  input  wire        nrst_i,
  // Bank selection from the bank select unit
  input  wire [1:0]  regbank_select_i,
  output wire [1:0]  active_bank_o,
  // Register port for instruction execution
  input  wire        reg_rd_wide_i,
  input  wire [2:0]  reg_rd_nib_i,
  input  wire [2:0]  reg_rd_pair_i,
  input  wire        reg_rd_alt_i,
  output wire [7:0]  reg_rdata_o,
  input  wire        reg_wr_i,
  input  wire        reg_wr_wide_i,
  input  wire [2:0]  reg_wr_nib_i,
  input  wire [2:0]  reg_wr_pair_i,
  input  wire        reg_wr_alt_i,
  input  wire [7:0]  reg_wdata_i,
  // Data memory port
  input  wire        mem_en_i,
  input  wire        mem_we_i,
  input  wire        mem_wide_i,
  input  wire [11:0] mem_addr_i,
  input  wire [7:0]  mem_wdata_i,
  output reg  [7:0]  mem_rdata_o,
  output reg         mem_hit_o,
  // Stack
  input  wire        push_i,
  input  wire        pop_i,
  output wire [11:0] stack_addr_o,
  output wire [7:0]  stack_pointer_o,
  output wire [3:0]  stack_bank_select_o,
  output wire        legacy_mode_o,
  output wire        extended_mode_o,
  // Status word save and restore
  input  wire        call_i,
  input  wire        ret_i,
  input  wire        irq_accept_i,
  input  wire        interrupt_return_op_i,
  input  wire        irq_rbe_i,
  input  wire        irq_mbe_i,
  input  wire [7:0]  psw_restore_i,
  output wire [7:0]  psw_save_o,
  output wire [7:0]  status_word_o,
  // Carry, skip, interrupt level and expand flags
  input  wire [3:0]  carry_op_i,
  input  wire        carry_bit_i,
  input  wire        carry_arith_i,
  output wire        carry_flag_o,
  input  wire        skip_we_i,
  input  wire [2:0]  skip_i,
  output wire [1:0]  irq_level_o,
  output wire        regbank_expand_flag_o,
  output wire        membank_expand_flag_o
);

  reg  [7:0] sp_reg;
  reg  [7:0] sp_next;
  reg  [3:0] sbs_reg;
  reg  [3:0] sbs_next;
  reg        cy_reg;
  reg        cy_next;
  reg  [2:0] sk_reg;
  reg  [2:0] sk_next;
  reg  [1:0] ist_reg;
  reg  [1:0] ist_next;
  reg        mbe_reg;
  reg        mbe_next;
  reg        rbe_reg;
  reg        rbe_next;

  wire [1:0] bank;
  wire [1:0] alt_bank;
  wire [7:0] program_status_word;
  wire [7:0] rf_a;
  wire [7:0] rf_b;

  //--------------------------------------------------------
  // Bank selection
  //--------------------------------------------------------
  assign bank     = regbank_select_i & {2{rbe_reg}}; // [RULE2] [RULE23]
  assign alt_bank = {bank[1], ~bank[0]};             // [RULE4]
  assign active_bank_o = bank;

  // Nibble offset of a pair's low and high half
  function [5:0] pair_offs;
    input [2:0] code;
    begin
      case (code)
        `CRSSU_PAIR_XA: pair_offs = {`CRSSU_NIB_X, `CRSSU_NIB_A};
        `CRSSU_PAIR_HL: pair_offs = {`CRSSU_NIB_H, `CRSSU_NIB_L};
        `CRSSU_PAIR_DE: pair_offs = {`CRSSU_NIB_D, `CRSSU_NIB_E};
        `CRSSU_PAIR_BC: pair_offs = {`CRSSU_NIB_B, `CRSSU_NIB_C};
        `CRSSU_PAIR_DL: pair_offs = {`CRSSU_NIB_D, `CRSSU_NIB_L};
        default:        pair_offs = {`CRSSU_NIB_X, `CRSSU_NIB_A};
      endcase
    end
  endfunction

  //--------------------------------------------------------
  // Register port decode
  //--------------------------------------------------------
  // Pair code zero is the wide accumulator, nibble A the narrow one
  wire [5:0] rd_po = pair_offs(reg_rd_pair_i);            // [RULE6]
  wire [5:0] wr_po = pair_offs(reg_wr_pair_i);
  wire [1:0] rd_bk = (reg_rd_wide_i && reg_rd_alt_i) ?
                     alt_bank : bank;                      // [RULE4]
  wire [1:0] wr_bk = (reg_wr_wide_i && reg_wr_alt_i) ?
                     alt_bank : bank;
  wire [4:0] rd_lo = reg_rd_wide_i ? {rd_bk, rd_po[2:0]} :
                     {rd_bk, reg_rd_nib_i};                // [RULE3]
  wire [4:0] rd_hi = {rd_bk, rd_po[5:3]};
  wire [4:0] wr_lo = reg_wr_wide_i ? {wr_bk, wr_po[2:0]} :
                     {wr_bk, reg_wr_nib_i};                // [RULE3]
  wire [4:0] wr_hi = {wr_bk, wr_po[5:3]};

  assign reg_rdata_o = reg_rd_wide_i ? rf_a : {4'h0, rf_a[3:0]};

  //--------------------------------------------------------
  // Data memory decode
  //--------------------------------------------------------
  wire       m_reg  = mem_en_i && (mem_addr_i <= `CRSSU_REG_TOP);
  wire       m_sp   = mem_en_i && (mem_addr_i == `CRSSU_ADDR_SP);
  wire       m_sbs  = mem_en_i && (mem_addr_i == `CRSSU_ADDR_SBS);
  wire       m_pswl = mem_en_i && (mem_addr_i == `CRSSU_ADDR_PSW_LO);
  wire       m_pswh = mem_en_i && (mem_addr_i == `CRSSU_ADDR_PSW_HI);
  wire [4:0] m_lo   = mem_addr_i[4:0];
  wire [4:0] m_hi   = mem_addr_i[4:0] + 5'h01;

  // Execution writes take the port ahead of memory writes
  wire       mw     = m_reg && mem_we_i && !reg_wr_i;      // [RULE5]
  wire       we_lo  = reg_wr_i || mw;
  wire       we_hi  = (reg_wr_i && reg_wr_wide_i) ||
                      (mw && mem_wide_i);
  wire [4:0] wa_lo  = reg_wr_i ? wr_lo : m_lo;
  wire [4:0] wa_hi  = reg_wr_i ? wr_hi : m_hi;
  wire [7:0] wd     = reg_wr_i ? reg_wdata_i : mem_wdata_i;

  crssu_regfile
  #(
    .NIBS (32),
    .AW   (5)
  )
  u_regfile
  (
    .clk_i   (clk_i),
    .we_lo_i (we_lo),
    .we_hi_i (we_hi),
    .wa_lo_i (wa_lo),
    .wa_hi_i (wa_hi),
    .wd_i    (wd),
    .ra_lo_i (rd_lo),
    .ra_hi_i (rd_hi),
    .ra_o    (rf_a),
    .rb_lo_i (m_lo),
    .rb_hi_i (m_hi),
    .rb_o    (rf_b)
  );                                                       // [RULE1]

  //--------------------------------------------------------
  // Memory read data, one cycle after the request
  //--------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      mem_rdata_o <= 8'h00;
      mem_hit_o   <= 1'b0;
    end
    else
    begin
      mem_hit_o <= m_reg || m_sp || m_sbs || m_pswl || m_pswh;
      if (m_reg)
        mem_rdata_o <= mem_wide_i ? rf_b : {4'h0, rf_b[3:0]}; // [RULE5]
      else if (m_sp)
        mem_rdata_o <= sp_reg;                                // [RULE9]
      else if (m_sbs)
        mem_rdata_o <= {4'h0, sbs_reg};                       // [RULE9]
      else if (m_pswl)
        mem_rdata_o <= mem_wide_i ? program_status_word : {4'h0, program_status_word[3:0]};   // [RULE14]
      else if (m_pswh)
        mem_rdata_o <= {4'h0, program_status_word[7:4]};
      else
        mem_rdata_o <= 8'h00;
    end
  end

  //--------------------------------------------------------
  // Stack pointer and stack bank
  //--------------------------------------------------------
  // Eight-bit arithmetic keeps the address inside the bank
  wire [7:0] sp_dec = sp_reg - 8'h01;                      // [RULE10] [RULE11]
  wire [7:0] sp_low = push_i ? sp_dec : sp_reg;            // [RULE8]

  assign stack_addr_o = {3'h0, sbs_reg[`CRSSU_SBS_BANK], sp_low}; // [RULE7]
  assign stack_pointer_o     = sp_reg;
  assign stack_bank_select_o = sbs_reg;
  assign legacy_mode_o       = sbs_reg[`CRSSU_SBS_MODE];    // [RULE13]
  assign extended_mode_o     = ~sbs_reg[`CRSSU_SBS_MODE];   // [RULE13]

  always @*
  begin
    sp_next  = sp_reg;
    sbs_next = sbs_reg;
    if (push_i)
      sp_next = sp_dec;                                    // [RULE8]
    else if (pop_i)
      sp_next = sp_reg + 8'h01;                            // [RULE8]
    else if (m_sp && mem_we_i && mem_wide_i)
      sp_next = mem_wdata_i;                               // [RULE9]
    if (m_sbs && mem_we_i)
      sbs_next = mem_wdata_i[3:0];                         // [RULE9]
  end

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      sp_reg  <= `CRSSU_SP_RST;
      sbs_reg <= `CRSSU_SBS_RST;                           // [RULE12]
    end
    else
    begin
      sp_reg  <= sp_next;
      sbs_reg <= sbs_next;
    end
  end

  //--------------------------------------------------------
  // Status word
  //--------------------------------------------------------
  assign program_status_word = {cy_reg, sk_reg, ist_reg, mbe_reg, rbe_reg};
  assign status_word_o = program_status_word;
  assign psw_save_o    = call_i ?
                         {6'h00, mbe_reg, rbe_reg} : program_status_word;  // [RULE15]
  assign carry_flag_o  = cy_reg;                           // [RULE17]
  assign irq_level_o   = ist_reg;
  assign regbank_expand_flag_o = rbe_reg;
  assign membank_expand_flag_o = mbe_reg;

  always @*
  begin
    cy_next  = cy_reg;
    sk_next  = sk_reg;
    ist_next = ist_reg;
    mbe_next = mbe_reg;
    rbe_next = rbe_reg;
    case (carry_op_i)
      `CRSSU_CY_SET:   cy_next = 1'b1;                     // [RULE17]
      `CRSSU_CY_CLR:   cy_next = 1'b0;                     // [RULE17]
      `CRSSU_CY_NOT:   cy_next = ~cy_reg;                  // [RULE17]
      `CRSSU_CY_LOAD:  cy_next = carry_bit_i;              // [RULE17]
      `CRSSU_CY_AND:   cy_next = cy_reg & carry_bit_i;     // [RULE17]
      `CRSSU_CY_OR:    cy_next = cy_reg | carry_bit_i;     // [RULE17]
      `CRSSU_CY_XOR:   cy_next = cy_reg ^ carry_bit_i;     // [RULE17]
      `CRSSU_CY_ARITH: cy_next = carry_arith_i;            // [RULE16]
      default:         cy_next = cy_reg;
    endcase
    // Skip bits have no memory write path
    if (skip_we_i)
      sk_next = skip_i;                                    // [RULE19]
    if (m_pswl && mem_we_i)
    begin
      // Level writes rely on software masking interrupts   [RULE22]
      ist_next = mem_wdata_i[`CRSSU_PSW_IRQ_LEVEL_HI:`CRSSU_PSW_IRQ_LEVEL_LO];
      mbe_next = mem_wdata_i[`CRSSU_PSW_MBE];              // [RULE14]
      rbe_next = mem_wdata_i[`CRSSU_PSW_RBE];              // [RULE14]
    end
    if (interrupt_return_op_i)
    begin
      cy_next  = psw_restore_i[`CRSSU_PSW_CY];             // [RULE15]
      sk_next  = psw_restore_i[`CRSSU_PSW_SK2:`CRSSU_PSW_SK0];
      ist_next = psw_restore_i[`CRSSU_PSW_IRQ_LEVEL_HI:`CRSSU_PSW_IRQ_LEVEL_LO]; // [RULE21]
      mbe_next = psw_restore_i[`CRSSU_PSW_MBE];
      rbe_next = psw_restore_i[`CRSSU_PSW_RBE];
    end
    else if (irq_accept_i)
    begin
      if (ist_reg < `CRSSU_IST_TOP)
        ist_next = ist_reg + 2'h1;                         // [RULE20] [RULE21]
      mbe_next = irq_mbe_i;
      rbe_next = irq_rbe_i;
    end
    else if (ret_i)
    begin
      mbe_next = psw_restore_i[`CRSSU_PSW_MBE];            // [RULE15]
      rbe_next = psw_restore_i[`CRSSU_PSW_RBE];
    end
  end

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      // Carry is cleared only so that it is never unknown  [RULE18]
      cy_reg  <= 1'b0;
      sk_reg  <= 3'h0;
      ist_reg <= 2'h0;
      mbe_reg <= 1'b0;
      rbe_reg <= 1'b0;
    end
    else
    begin
      cy_reg  <= cy_next;
      sk_reg  <= sk_next;
      ist_reg <= ist_next;
      mbe_reg <= mbe_next;
      rbe_reg <= rbe_next;
    end
  end

endmodule // crssu_core
`default_nettype wire

// ---- core/crssu_defines.vh ----
// Constants shared by the register, stack and status core
`ifndef CRSSU_DEFINES_VH
`define CRSSU_DEFINES_VH

// Data memory addresses
`define CRSSU_REG_TOP      12'h01f
`define CRSSU_ADDR_SP      12'hf80
`define CRSSU_ADDR_SBS     12'hf84
`define CRSSU_ADDR_PSW_LO  12'hfb0
`define CRSSU_ADDR_PSW_HI  12'hfb1

// Reset values
`define CRSSU_SBS_RST      4'h8
`define CRSSU_SP_RST       8'h00

// Status word bit positions
`define CRSSU_PSW_CY       7
`define CRSSU_PSW_SK2      6
`define CRSSU_PSW_SK1      5
`define CRSSU_PSW_SK0      4
`define CRSSU_PSW_IRQ_LEVEL_HI     3
`define CRSSU_PSW_IRQ_LEVEL_LO     2
`define CRSSU_PSW_MBE      1
`define CRSSU_PSW_RBE      0

// Stack bank select bit positions
`define CRSSU_SBS_MODE     3
`define CRSSU_SBS_BANK     0

// Nibble offsets inside a bank
`define CRSSU_NIB_A        3'h0
`define CRSSU_NIB_X        3'h1
`define CRSSU_NIB_L        3'h2
`define CRSSU_NIB_H        3'h3
`define CRSSU_NIB_E        3'h4
`define CRSSU_NIB_D        3'h5
`define CRSSU_NIB_C        3'h6
`define CRSSU_NIB_B        3'h7

// Register pair codes
`define CRSSU_PAIR_XA      3'h0
`define CRSSU_PAIR_HL      3'h1
`define CRSSU_PAIR_DE      3'h2
`define CRSSU_PAIR_BC      3'h3
`define CRSSU_PAIR_DL      3'h4

// Carry operation codes
`define CRSSU_CY_NOP       4'h0
`define CRSSU_CY_SET       4'h1
`define CRSSU_CY_CLR       4'h2
`define CRSSU_CY_NOT       4'h3
`define CRSSU_CY_LOAD      4'h4
`define CRSSU_CY_AND       4'h5
`define CRSSU_CY_OR        4'h6
`define CRSSU_CY_XOR       4'h7
`define CRSSU_CY_ARITH     4'h8

// Interrupt status levels
`define CRSSU_IST_TOP      2'h2

`endif

// ---- core/crssu_regfile.v ----
// General register storage: four banks of eight nibbles
`timescale 1ns/100ps
`default_nettype none
module crssu_regfile
#(
  parameter NIBS = 32,
  parameter AW   = 5
)
(
  input  wire          clk_i,
  input  wire          we_lo_i,
  input  wire          we_hi_i,
  input  wire [AW-1:0] wa_lo_i,
  input  wire [AW-1:0] wa_hi_i,
  input  wire [7:0]    wd_i,
  input  wire [AW-1:0] ra_lo_i,
  input  wire [AW-1:0] ra_hi_i,
  output wire [7:0]    ra_o,
  input  wire [AW-1:0] rb_lo_i,
  input  wire [AW-1:0] rb_hi_i,
  output wire [7:0]    rb_o
);

  wire [4*NIBS-1:0] flat;

  //--------------------------------------------------------
  // Storage, one nibble per entry
  //--------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NIBS; g = g + 1)
    begin : g_nib
      reg [3:0] nib_reg;
      always @(posedge clk_i)
      begin
        if (we_hi_i && (wa_hi_i == g))
          nib_reg <= wd_i[7:4];
        else if (we_lo_i && (wa_lo_i == g))
          nib_reg <= wd_i[3:0];
      end
      assign flat[4*g+3:4*g] = nib_reg;
    end
  endgenerate

  assign ra_o = {flat[4*ra_hi_i +: 4], flat[4*ra_lo_i +: 4]};
  assign rb_o = {flat[4*rb_hi_i +: 4], flat[4*rb_lo_i +: 4]};

endmodule // crssu_regfile
`default_nettype wire
